//--- dcc_assertions.sv
`timescale 1ns/1ps
module dcc_checker #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic              pclk,      // Clock
  input wire logic              presetn,   // Reset
  input wire logic              psel,      // Select
  input wire logic              penable,   // Access
  input wire logic              pwrite,    // Write
  input wire logic [ADDR_W-1:0] paddr,     // Address
  input wire logic [31:0]       pwdata,    // Write data
  input wire logic [31:0]       prdata,    // Read data
  input wire logic              pready,    // Ready
  input wire logic              pslverr,   // Error
  input dcc_pkg::dcc_mem_req_t  mem_out,   // Request
  input wire logic [31:0]       mem_rdata, // Bus data
  input wire logic              mem_ack,   // Bus done
  input wire logic              fill_hold, // Fill lock
  input wire logic              irq        // Pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  dcc_pkg::dcc_ctrl_t ctl;
  logic [31:0]        last_rd;
  logic               armed;
  wire                setup  = psel && !penable;
  wire                wack   = mem_ack && mem_out.we;
  wire                at_ctl = paddr == 16'hd470;
  wire                wr_ctl = psel && penable && pready && pwrite && at_ctl;
  wire                rd_ctl = pready && !pwrite && at_ctl;
  // Shadow mirrors every control write but keeps reserved bits unmasked and misses the auto-clear of the on bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl     <= '0;
      armed   <= 1'b0;
      last_rd <= 32'h0;
    end else begin
      if (wr_ctl) ctl <= pwdata[15:0];
      if (wr_ctl && pwdata[0]) armed <= 1'b1;
      if (mem_ack && !mem_out.we) last_rd <= mem_rdata;
    end
  end
  a_ready_once: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_bad_addr: assert property (setup && paddr == 0 |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_resv_zero: assert property (rd_ctl |-> prdata[31:13] == 0)
    else $error("reserved control bits not zero");
  a_irq_cause: assert property (irq |-> ctl.irq_enable &&
    ($past(wack) || $past(wack, 2)))
    else $error("interrupt without enabled store");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_fill_only: assert property (fill_hold |-> ctl.fill)
    else $error("fill hold outside fill mode");
  a_idle_off: assert property (!armed |-> !mem_out.req)
    else $error("bus request while channel never enabled");
  a_req_holds: assert property (mem_out.req && !mem_ack |=>
    $stable(mem_out))
    else $error("bus request changed before acknowledge");
  a_copy_data: assert property (mem_out.req && mem_out.we |->
    mem_out.wdata == last_rd)
    else $error("stored data differs from fetched data");
  a_width_code: assert property (mem_out.req |->
    mem_out.size == ctl.bus_width)
    else $error("bus size differs from width field");
endmodule // dcc_checker

//--- dcc_channel.sv
`timescale 1ns/1ps
module dcc_channel #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic                      pclk,       // System clock
  input  wire logic                      presetn,    // Async reset
  input  wire logic                      psel,       // APB select
  input  wire logic                      penable,    // APB enable
  input  wire logic                      pwrite,     // APB direction
  input  wire logic [ADDR_W-1:0]         paddr,      // APB byte address
  input  wire logic [31:0]               pwdata,     // APB write data
  output logic      [31:0]               prdata,     // APB read data
  output logic                           pready,     // APB ready
  output logic                           pslverr,    // APB error
  output dcc_pkg::dcc_mem_req_t          mem_out,    // Bus master request
  input  wire logic [31:0]               mem_rdata,  // Bus read data
  input  wire logic                      mem_ack,    // Bus access done
  input  wire logic                      periph_req, // Peripheral request pin
  input  wire logic                      peer_req,   // Channel 0 wants bus
  input  wire logic [2:0]                peer_prio,  // Channel 0 priority
  output logic                           bus_lock,   // Deny lower masters
  output logic                           fill_hold,  // Fill not preemptible
  output logic                           irq         // Threshold pulse
);

  localparam int unsigned AW = ADDR_W - 2;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [31:0]       idx);
    reg_hit = (a[ADDR_W-1:2] == idx[AW-1:0]);
  endfunction

  // Start plus index scaled by width; reserved width acts as word
  function automatic logic [31:0] item_addr(input logic [31:0] base,
                                            input logic [15:0] idx,
                                            input logic        inc,
                                            input logic [1:0]  bw);
    logic [31:0] off;
    off = {16'h0000, idx};
    if (!inc) begin
      item_addr = base;
    end else begin
      case (bw)
        dcc_pkg::BW_BYTE: item_addr = base + off;
        dcc_pkg::BW_HALF: item_addr = base + {off[30:0], 1'b0};
        default:          item_addr = base + {off[29:0], 2'b00};
      endcase
    end
  endfunction

  dcc_pkg::dcc_ctrl_t  ctrl;
  dcc_pkg::dcc_state_t state;
  dcc_pkg::dcc_state_t next_state;
  logic [15:0]         src_lo;
  logic [15:0]         src_hi;
  logic [15:0]         dst_lo;
  logic [15:0]         dst_hi;
  logic [15:0]         threshold;
  logic [15:0]         length;
  logic [15:0]         item_index;
  logic [31:0]         data_q;
  logic                req_s1;
  logic                req_s2;

  // Register decode
  wire logic hit_idx  = reg_hit(paddr, dcc_pkg::IDX_ITEM_INDEX);
  wire logic hit_sl   = reg_hit(paddr, dcc_pkg::IDX_SRC_LOW);
  wire logic hit_sh   = reg_hit(paddr, dcc_pkg::IDX_SRC_HIGH);
  wire logic hit_dl   = reg_hit(paddr, dcc_pkg::IDX_DST_LOW);
  wire logic hit_dh   = reg_hit(paddr, dcc_pkg::IDX_DST_HIGH);
  wire logic hit_thr  = reg_hit(paddr, dcc_pkg::IDX_THRESHOLD);
  wire logic hit_len  = reg_hit(paddr, dcc_pkg::IDX_LENGTH);
  wire logic hit_ctl  = reg_hit(paddr, dcc_pkg::IDX_CONTROL);
  wire logic rd_hit   = hit_idx | hit_sl | hit_sh | hit_dl | hit_dh |
                        hit_thr | hit_len | hit_ctl;
  wire logic setup    = psel & ~penable;
  wire logic wr_en    = psel & penable & pready & pwrite & ~pslverr;

  wire logic [15:0] rd_half =
      hit_idx ? item_index :
      hit_sl  ? src_lo :
      hit_sh  ? src_hi :
      hit_dl  ? dst_lo :
      hit_dh  ? dst_hi :
      hit_thr ? threshold :
      hit_len ? length :
      hit_ctl ? (ctrl & dcc_pkg::CTRL_WMASK) :
      dcc_pkg::RST_HALF;

  // Engine decisions
  wire logic [31:0] src_base = {src_hi, src_lo};
  wire logic [31:0] dst_base = {dst_hi, dst_lo};
  wire logic [31:0] src_addr = item_addr(src_base, item_index,
                                 ctrl.source_increment & ~ctrl.fill,
                                 ctrl.bus_width);
  wire logic [31:0] dst_addr = item_addr(dst_base, item_index,
                                 ctrl.dest_increment,
                                 ctrl.bus_width);
  wire logic want_start = ctrl.on &
                          (~ctrl.request_trigger | req_s2);
  wire logic in_fill    = ctrl.fill & (item_index != dcc_pkg::RST_HALF);
  // Ties go to the peer, the lower-numbered channel
  wire logic prio_wins  = (ctrl.prio > peer_prio);
  wire logic granted    = ~peer_req | prio_wins |
                          in_fill;
  wire logic need_fetch = ~ctrl.fill |
                          (item_index == dcc_pkg::RST_HALF);
  wire logic last_item  = (item_index == length);
  wire logic pace_gap   = ctrl.yield & ~ctrl.request_trigger;
  wire logic write_done = (state == dcc_pkg::ST_WRITE) & mem_ack;
  wire logic read_done  = (state == dcc_pkg::ST_READ) & mem_ack;
  wire logic stop_now   = write_done & last_item & ~ctrl.circular;
  wire logic thr_hit    = write_done & ctrl.irq_enable &
                          (threshold == item_index);
  wire logic go_read    = (state == dcc_pkg::ST_ARB) &
                          (next_state == dcc_pkg::ST_READ);
  wire logic go_write   = (next_state == dcc_pkg::ST_WRITE) &
                          (state != dcc_pkg::ST_WRITE);
  wire logic active_nxt = (next_state != dcc_pkg::ST_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      dcc_pkg::ST_IDLE: begin
        if (want_start) begin
          next_state = dcc_pkg::ST_ARB;
        end
      end
      dcc_pkg::ST_ARB: begin
        if (!ctrl.on) begin
          next_state = dcc_pkg::ST_IDLE;
        end else if (granted) begin
          next_state = need_fetch ? dcc_pkg::ST_READ : dcc_pkg::ST_WRITE;
        end
      end
      dcc_pkg::ST_READ: begin
        if (mem_ack) begin
          next_state = dcc_pkg::ST_WRITE;
        end
      end
      dcc_pkg::ST_WRITE: begin
        if (mem_ack) begin
          if (!ctrl.on || stop_now || ctrl.request_trigger) begin
            next_state = dcc_pkg::ST_IDLE;
          end else if (pace_gap) begin
            next_state = dcc_pkg::ST_GAP;
          end else begin
            next_state = dcc_pkg::ST_ARB;
          end
        end
      end
      dcc_pkg::ST_GAP: begin
        next_state = ctrl.on ? dcc_pkg::ST_ARB : dcc_pkg::ST_IDLE;
      end
      default: begin
        next_state = dcc_pkg::ST_IDLE;
      end
    endcase
  end

  // Two-flop synchroniser for the peripheral request pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      req_s1 <= periph_req;
      req_s2 <= req_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dcc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // APB answer: no wait state, data and error latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~rd_hit;
        prdata  <= {16'h0000, rd_half};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_lo    <= dcc_pkg::RST_HALF;
      src_hi    <= dcc_pkg::RST_HALF;
      dst_lo    <= dcc_pkg::RST_HALF;
      dst_hi    <= dcc_pkg::RST_HALF;
      threshold <= dcc_pkg::RST_HALF;
      length    <= dcc_pkg::RST_HALF;
    end else if (wr_en) begin
      if (hit_sl)  src_lo    <= pwdata[15:0];
      if (hit_sh)  src_hi    <= pwdata[15:0];
      if (hit_dl)  dst_lo    <= pwdata[15:0];
      if (hit_dh)  dst_hi    <= pwdata[15:0];
      if (hit_thr) threshold <= pwdata[15:0];
      if (hit_len) length    <= pwdata[15:0];
    end
  end

  // Software write lands after the auto-clear, so a fresh enable survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dcc_pkg::dcc_ctrl_t'(dcc_pkg::RST_HALF);
    end else if (wr_en && hit_ctl) begin
      ctrl <= dcc_pkg::dcc_ctrl_t'(pwdata[15:0] & dcc_pkg::CTRL_WMASK);
    end else if (stop_now) begin
      ctrl.on <= 1'b0;
    end
  end

  // Index counts items; circular wraps to zero and keeps running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      item_index <= dcc_pkg::RST_HALF;
    end else if (write_done) begin
      if (!ctrl.on || last_item) begin
        item_index <= dcc_pkg::RST_HALF;
      end else begin
        item_index <= item_index + dcc_pkg::IDX_ONE;
      end
    end else if (state == dcc_pkg::ST_IDLE && !ctrl.on) begin
      item_index <= dcc_pkg::RST_HALF;
    end
  end

  // Fill mode replays this word into every destination item
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 32'h0000_0000;
    end else if (read_done) begin
      data_q <= mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_out <= '0;
    end else if (go_read) begin
      mem_out <= '{req: 1'b1, we: 1'b0, size: ctrl.bus_width,
                   addr: src_addr, wdata: 32'h0000_0000};
    end else if (go_write) begin
      mem_out <= '{req: 1'b1, we: 1'b1, size: ctrl.bus_width,
                   addr: dst_addr,
                   wdata: read_done ? mem_rdata : data_q};
    end else if (mem_ack) begin
      mem_out.req <= 1'b0;
    end
  end

  // Blocking mode holds off lower-priority masters while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_lock  <= 1'b0;
      fill_hold <= 1'b0;
      irq       <= 1'b0;
    end else begin
      bus_lock  <= active_nxt & ~pace_gap;
      fill_hold <= active_nxt & ctrl.fill;
      irq       <= thr_hit;
    end
  end

endmodule // dcc_channel

//--- dcc_mem_model.sv
`timescale 1ns/1ps
module dcc_mem_model (
  input wire logic             pclk,      // Clock
  input wire logic             presetn,   // Reset
  input dcc_pkg::dcc_mem_req_t mem_out,   // Request
  input wire logic [1:0]       lat,       // Extra waits
  output logic      [31:0]     mem_rdata, // Read data
  output logic                 mem_ack    // Done pulse
);
  logic [31:0] ra [16];
  logic [31:0] wa [16];
  logic [31:0] wd [16];
  logic [1:0]  cnt;
  int          rn, wn, gap, lastgap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      cnt       <= 2'h0;
      rn        <= 0;
      wn        <= 0;
    end else if (mem_out.req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt     <= 2'h0;
      if (mem_out.we) begin
        wa[wn % 16] <= mem_out.addr;
        wd[wn % 16] <= mem_out.wdata;
        wn          <= wn + 1;
      end else begin
        ra[rn % 16] <= mem_out.addr;
        rn          <= rn + 1;
        mem_rdata   <= mem_out.addr ^ 32'ha5a5_0000;
      end
    end else begin
      mem_ack   <= 1'b0;
      // Never leave last data standing between answers
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack) cnt <= cnt + 2'h1;
    end
  end
  // Idle cycles before each fetch; the last one is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap     <= 0;
      lastgap <= 0;
    end else if (mem_ack && mem_out.we) begin
      gap <= 0;
    end else if (!mem_out.req) begin
      gap <= gap + 1;
    end else if (!mem_out.we && gap != 0) begin
      lastgap <= gap;
      gap     <= 0;
    end
  end
endmodule // dcc_mem_model

//--- dcc_pkg.sv
package dcc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;

  // Printed offsets are register indices; byte address is four times each
  localparam logic [31:0] IDX_ITEM_INDEX  = 32'h5000_350e;
  localparam logic [31:0] IDX_SRC_LOW     = 32'h5000_3510;
  localparam logic [31:0] IDX_SRC_HIGH    = 32'h5000_3512;
  localparam logic [31:0] IDX_DST_LOW     = 32'h5000_3514;
  localparam logic [31:0] IDX_DST_HIGH    = 32'h5000_3516;
  localparam logic [31:0] IDX_THRESHOLD   = 32'h5000_3518;
  localparam logic [31:0] IDX_LENGTH      = 32'h5000_351a;
  localparam logic [31:0] IDX_CONTROL     = 32'h5000_351c;

  localparam logic [15:0] RST_HALF        = 16'h0000;
  localparam logic [15:0] CTRL_WMASK      = 16'h1fff;
  localparam logic [15:0] IDX_ONE         = 16'h0001;

  localparam logic [1:0]  BW_BYTE         = 2'h0;
  localparam logic [1:0]  BW_HALF         = 2'h1;
  localparam logic [1:0]  BW_WORD         = 2'h2;

  typedef struct packed {
    logic [2:0] reserved;
    logic       fill;
    logic       yield;
    logic [2:0] prio;
    logic       circular;
    logic       source_increment;
    logic       dest_increment;
    logic       request_trigger;
    logic       irq_enable;
    logic [1:0] bus_width;
    logic       on;
  } dcc_ctrl_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [1:0]        size;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcc_mem_req_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_ARB   = 5'b0_0010,
    ST_READ  = 5'b0_0100,
    ST_WRITE = 5'b0_1000,
    ST_GAP   = 5'b1_0000
  } dcc_state_t;

endpackage

//--- dma_channel_controller_bench.sv
`timescale 1ns/1ps
module dma_channel_controller_bench;
  logic        pclk, pready, pslverr, bus_lock, fill_hold, irq, mem_ack, ev;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        periph_req = 1'b0, peer_req = 1'b0, steal = 1'b0;
  logic [1:0]  lat = 2'h1;
  logic [2:0]  peer_prio = 3'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, rv;
  int          bad_count, samples_checked, cyc, irqs, fills, g0, locks;
  dcc_pkg::dcc_mem_req_t mem_out;
  localparam logic [15:0] AD [8] = '{16'hd438, 16'hd440, 16'hd448,
    16'hd450, 16'hd458, 16'hd460, 16'hd468, 16'hd470};
  localparam logic [31:0] SRC = 32'h2000_1000;
  localparam logic [31:0] DST = 32'h3000_0800;
  dcc_channel #(.ADDR_W(16)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .periph_req(periph_req), .peer_req(peer_req), .peer_prio(peer_prio),
    .bus_lock(bus_lock), .fill_hold(fill_hold), .irq(irq));
  dcc_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_out(mem_out),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irqs++;
    if (fill_hold === 1'b1) fills++;
    if (bus_lock === 1'b1) locks++;
    // Higher-priority peer arrives once the single fetch is done
    if (steal && mem_ack === 1'b1) peer_req <= 1'b1;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, AD[i], 32'h0);
      chk(rv, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, AD[i], 32'hffff_0000 | (i + 1) * 32'h1111);
      apb(1'b0, AD[i], 32'h0);
      chk(rv, i ? (i + 1) * 32'h1111 : 32'h0);
    end
    apb(1'b1, AD[7], 32'h0000_fffe);
    apb(1'b0, AD[7], 32'h0);
    chk(rv, 32'h0000_1ffe);
    apb(1'b1, AD[7], 32'h0);
    apb(1'b0, 16'h0, 32'h0);
    chk(ev, 1'b1);
  endtask
  task automatic run(input logic [15:0] ct, input int len, input int thr);
    int          r0, w0, st, dt;
    logic [31:0] s;
    logic [15:0] v [7];
    r0 = mem.rn;
    w0 = mem.wn;
    irqs = 0;
    v = '{SRC[15:0], SRC[31:16], DST[15:0], DST[31:16], 16'(thr),
          16'(len), ct};
    for (int i = 0; i < 7; i++) apb(1'b1, AD[i + 1], {16'h0, v[i]});
    do apb(1'b0, AD[7], 32'h0); while (rv[0] === 1'b1);
    st = ct[6] ? 1 << ct[2:1] : 0;
    dt = ct[5] ? 1 << ct[2:1] : 0;
    chk(mem.rn - r0, ct[12] ? 1 : len + 1);
    chk(mem.wn - w0, len + 1);
    for (int k = 0; k <= len; k++) begin
      s = SRC + (ct[12] ? 0 : k * st);
      if (k == 0 || !ct[12]) chk(mem.ra[(r0 + k) % 16], s);
      chk(mem.wa[(w0 + k) % 16], DST + k * dt);
      chk(mem.wd[(w0 + k) % 16], s ^ 32'ha5a5_0000);
    end
    apb(1'b0, AD[0], 32'h0);
    chk(rv, 32'h0);
    chk(irqs, ct[3] && thr <= len);
  endtask
  task automatic t_pace();
    locks = 0;
    run(16'h006d, 3, 3);
    chk(locks > 0, 1'b1);
    g0 = mem.lastgap;
    run(16'h086d, 3, 3);
    chk(mem.lastgap, g0 + 1);
  endtask
  task automatic t_width();
    for (int b = 0; b < 3; b++) begin
      run(16'h0061 | 16'(b << 1), 2, 0);
    end
    run(16'h006d, 0, 0);
    lat <= 2'h3;
    run(16'h0025, 1, 0);
    lat <= 2'h1;
  endtask
  task automatic t_fill();
    fills = 0;
    peer_prio <= 3'h7;
    steal = 1'b1;
    run(16'h1065, 3, 9);
    steal = 1'b0;
    peer_req <= 1'b0;
    chk(fills > 0, 1'b1);
  endtask
  task automatic t_prio();
    int r0;
    r0 = mem.rn;
    peer_req  <= 1'b1;
    peer_prio <= 3'h3;
    apb(1'b1, AD[6], 32'h0);
    apb(1'b1, AD[7], 32'h0000_0365);
    repeat (30) @(posedge pclk);
    chk(mem.rn - r0, 0);
    // Park the channel, else the lowered peer lets it run mid-setup
    apb(1'b1, AD[7], 32'h0);
    peer_prio <= 3'h2;
    run(16'h0365, 0, 9);
    peer_req <= 1'b0;
  endtask
  task automatic t_circ();
    int w0, n;
    w0 = mem.wn;
    apb(1'b1, AD[6], 32'h1);
    apb(1'b1, AD[7], 32'h0000_08b5);
    repeat (20) @(posedge pclk);
    chk(mem.wn - w0, 0);
    for (int k = 0; k < 4; k++) begin
      n = mem.wn;
      periph_req <= 1'b1;
      do @(posedge pclk); while (mem_out.req !== 1'b1);
      periph_req <= 1'b0;
      do @(posedge pclk); while (mem.wn == n);
      repeat (6) @(posedge pclk);
      chk(mem.wa[(w0 + k) % 16], DST + (k % 2) * 4);
    end
    chk(mem.wn - w0, 4);
    apb(1'b0, AD[7], 32'h0);
    chk(rv[0], 1'b1);
    apb(1'b1, AD[7], 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pace();
    t_width();
    t_fill();
    t_prio();
    t_circ();
    give_verdict();
  end
endmodule // dma_channel_controller_bench
bind dcc_channel dcc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_out(mem_out), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .fill_hold(fill_hold), .irq(irq));
